/* File: rtl/dscd_pkg.sv */
package dscd_pkg;

  localparam int FIRST_WIDTH = 4;
  localparam int SECOND_WIDTH = 2;

  // Select pin encodings
  localparam logic SEL_ECL = 1'b0;
  localparam logic SEL_TTL = 1'b1;

  // Forced levels of an open differential pair
  localparam logic OPEN_POS_LEVEL = 1'b0;
  localparam logic OPEN_NEG_LEVEL = 1'b1;

  // Reset levels of the outputs
  localparam logic TRUE_RST = 1'b0;
  localparam logic COMP_RST = 1'b1;

  typedef struct packed {
    logic pos;
    logic neg;
    logic pos_open;
    logic neg_open;
  } dscd_diff_in_t;

  typedef struct packed {
    logic [FIRST_WIDTH-1:0] first_true;
    logic [FIRST_WIDTH-1:0] first_comp;
    logic [SECOND_WIDTH-1:0] second_true;
    logic [SECOND_WIDTH-1:0] second_comp;
  } dscd_clk_out_t;

endpackage : dscd_pkg

/* File: rtl/dscd_divider.sv */
`timescale 1ns/10ps

module dscd_divider (
  input wire logic mclk,
  input wire logic nrst,
  input wire dscd_pkg::dscd_diff_in_t ecl_clock_in,
  input wire logic ttl_clock_in,
  input wire logic source_select,
  output dscd_pkg::dscd_clk_out_t clk_out
);

  // Divider phase, Gray coded along the count
  typedef enum logic [1:0] {
    PH_BOTH_LOW = 2'h0,
    PH_BOTH_HIGH = 2'h1,
    PH_HALF_LOW = 2'h3,
    PH_QUARTER_LOW = 2'h2
  } dscd_phase_t;

  // Differential level with the open-pair fallback
  function automatic logic resolve_diff(
    input dscd_pkg::dscd_diff_in_t pair
  );
    logic pos_level;
    logic neg_level;
    pos_level = pair.pos;
    neg_level = pair.neg;
    if (pair.pos_open && pair.neg_open) begin
      pos_level = dscd_pkg::OPEN_POS_LEVEL;
      neg_level = dscd_pkg::OPEN_NEG_LEVEL;
    end
    return pos_level & ~neg_level;
  endfunction : resolve_diff

  // Source choice
  function automatic logic pick_source(
    input logic select,
    input logic ecl_level,
    input logic single_level
  );
    logic picked;
    if (select == dscd_pkg::SEL_TTL) begin
      picked = single_level;
    end else begin
      picked = ecl_level;
    end
    return picked;
  endfunction : pick_source

  // One step along the count
  function automatic dscd_phase_t advance_phase(
    input dscd_phase_t phase
  );
    dscd_phase_t step;
    case (phase)
      PH_BOTH_LOW: begin
        step = PH_BOTH_HIGH;
      end
      PH_BOTH_HIGH: begin
        step = PH_HALF_LOW;
      end
      PH_HALF_LOW: begin
        step = PH_QUARTER_LOW;
      end
      PH_QUARTER_LOW: begin
        step = PH_BOTH_LOW;
      end
      default: begin
        step = PH_BOTH_LOW;
      end
    endcase
    return step;
  endfunction : advance_phase

  // Half-rate level of a phase
  function automatic logic half_level(
    input dscd_phase_t phase
  );
    logic level;
    case (phase)
      PH_BOTH_LOW: begin
        level = 1'h0;
      end
      PH_BOTH_HIGH: begin
        level = 1'h1;
      end
      PH_HALF_LOW: begin
        level = 1'h0;
      end
      PH_QUARTER_LOW: begin
        level = 1'h1;
      end
      default: begin
        level = 1'h0;
      end
    endcase
    return level;
  endfunction : half_level

  // Quarter-rate level of a phase
  function automatic logic quarter_level(
    input dscd_phase_t phase
  );
    logic level;
    case (phase)
      PH_BOTH_LOW: begin
        level = 1'h0;
      end
      PH_BOTH_HIGH: begin
        level = 1'h1;
      end
      PH_HALF_LOW: begin
        level = 1'h1;
      end
      PH_QUARTER_LOW: begin
        level = 1'h0;
      end
      default: begin
        level = 1'h0;
      end
    endcase
    return level;
  endfunction : quarter_level

  // Conditioned input and its rise
  logic diff_level;
  logic sel_clk;
  logic in_prev_r;
  logic in_prev_nxt;
  logic in_rise;

  // Divider phase and rate levels
  dscd_phase_t phase_r;
  dscd_phase_t phase_nxt;
  logic half_nxt;
  logic quarter_nxt;

  // Next values of every output pin
  logic [dscd_pkg::FIRST_WIDTH-1:0] first_true_nxt;
  logic [dscd_pkg::FIRST_WIDTH-1:0] first_comp_nxt;
  logic [dscd_pkg::SECOND_WIDTH-1:0] second_true_nxt;
  logic [dscd_pkg::SECOND_WIDTH-1:0] second_comp_nxt;
  dscd_pkg::dscd_clk_out_t out_r;
  dscd_pkg::dscd_clk_out_t out_nxt;

  // Input conditioning and source choice
  always_comb begin
    diff_level = resolve_diff(ecl_clock_in);
    sel_clk = pick_source(source_select, diff_level, ttl_clock_in);
  end

  // Rise detector on the selected input
  always_comb begin
    in_prev_nxt = sel_clk;
    in_rise = sel_clk & ~in_prev_r;
  end

  // Edge history rests at the idle level of the input
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      in_prev_r <= 1'h0;
    end else begin
      in_prev_r <= in_prev_nxt;
    end
  end

  // Divider phase; reset leaves both stages low so the first rise lifts both
  always_comb begin
    phase_nxt = phase_r;
    if (in_rise) begin
      phase_nxt = advance_phase(phase_r);
    end
    half_nxt = half_level(phase_nxt);
    quarter_nxt = quarter_level(phase_nxt);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= PH_BOTH_LOW;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Fan the two rates out to every output pin
  for (genvar i = 0; i < dscd_pkg::FIRST_WIDTH; i++) begin : g_first
    assign first_true_nxt[i] = half_nxt;
    assign first_comp_nxt[i] = ~half_nxt;
  end

  for (genvar j = 0; j < dscd_pkg::SECOND_WIDTH; j++) begin : g_second
    assign second_true_nxt[j] = quarter_nxt;
    assign second_comp_nxt[j] = ~quarter_nxt;
  end

  // Pack the output carrier
  always_comb begin
    out_nxt.first_true = first_true_nxt;
    out_nxt.first_comp = first_comp_nxt;
    out_nxt.second_true = second_true_nxt;
    out_nxt.second_comp = second_comp_nxt;
  end

  // Registered outputs; reset forces true pins low and complements high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_r.first_true <= {dscd_pkg::FIRST_WIDTH{dscd_pkg::TRUE_RST}};
      out_r.first_comp <= {dscd_pkg::FIRST_WIDTH{dscd_pkg::COMP_RST}};
      out_r.second_true <= {dscd_pkg::SECOND_WIDTH{dscd_pkg::TRUE_RST}};
      out_r.second_comp <= {dscd_pkg::SECOND_WIDTH{dscd_pkg::COMP_RST}};
    end else begin
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;

endmodule : dscd_divider

/* File: verification/dscd_checker.sv */
`timescale 1ns/10ps
module dscd_checker(
  input wire logic mclk,
  input wire logic nrst,
  input wire dscd_pkg::dscd_diff_in_t ecl_clock_in,
  input wire logic ttl_clock_in,
  input wire logic source_select,
  input wire dscd_pkg::dscd_clk_out_t clk_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic s = source_select ? ttl_clock_in : ecl_clock_in.pos & ~ecl_clock_in.neg
    & ~(ecl_clock_in.pos_open & ecl_clock_in.neg_open);
  sequence rise_s; !s ##1 s; endsequence
  a_reset_lvl: assert property (disable iff (0) !nrst |-> clk_out == 12'h0F3)
    else $error("reset level");
  a_half_rate: assert property (rise_s |=> clk_out.first_true == ~$past(clk_out.first_true))
    else $error("half rate");
  a_quarter_rate: assert property (rise_s ##0 clk_out.first_true == 4'h0
    |=> clk_out.second_true == ~$past(clk_out.second_true)) else $error("quarter rate");
  a_edge_align: assert property ($rose(clk_out.second_true[0]) |-> $rose(clk_out.first_true[0]))
    else $error("edges apart");
  a_output_hold: assert property (!s |=> $stable(clk_out)) else $error("spurious change");
  a_comp_inverse: assert property (clk_out.first_comp == ~clk_out.first_true
    && clk_out.second_comp == ~clk_out.second_true) else $error("complement mismatch");
  a_comp_fall: assert property ($changed(clk_out.second_true[0])
    |-> $fell(clk_out.first_comp[0])) else $error("quarter apart from complement fall");
endmodule : dscd_checker
bind dscd_divider dscd_checker dscd_checker_inst(
  .mclk(mclk),
  .nrst(nrst),
  .ecl_clock_in(ecl_clock_in),
  .ttl_clock_in(ttl_clock_in),
  .source_select(source_select),
  .clk_out(clk_out)
);

/* File: verification/dscd_mpu.sv */
`timescale 1ns/10ps
module dscd_mpu(
  input wire dscd_pkg::dscd_clk_out_t clk_in,
  output int n_quarter
);
  int count = 0;
  always @(posedge clk_in.second_true[0]) count++;
  assign n_quarter = count;
endmodule : dscd_mpu

/* File: verification/dscd_divider_bench.sv */
`timescale 1ns/10ps
module dscd_divider_bench;
  logic mclk = 1, nrst = 1, ttl_clock_in = 0, source_select = 1;
  dscd_pkg::dscd_diff_in_t d = '0;
  dscd_pkg::dscd_clk_out_t q;
  int n_errors = 0, n_compared = 0, nq;
  always #12.5 mclk = ~mclk;
  dscd_divider dscd_divider_inst(.mclk(mclk), .nrst(nrst), .ecl_clock_in(d),
    .ttl_clock_in(ttl_clock_in), .source_select(source_select), .clk_out(q));
  dscd_mpu dscd_mpu_inst(.clk_in(q), .n_quarter(nq));
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic pulse(input int n, input bit w);
    repeat (n) begin
      @(negedge mclk);
      ttl_clock_in = w;
      d.pos = !w;
      @(negedge mclk);
      ttl_clock_in = 0;
      d.pos = 0;
    end
    @(negedge mclk);
  endtask : pulse
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic run_reset_entry;
    @(negedge mclk);
    nrst = 0;
    repeat (2) @(negedge mclk);
    chk(q, 12'h0F3);
    nrst = 1;
  endtask : run_reset_entry
  task automatic run_ttl_division;
    pulse(3, 1);
    chk(q, 12'hF03);
  endtask : run_ttl_division
  task automatic run_source_choice;
    source_select = 0;
    pulse(2, 1);
    chk(q, 12'hF03);
    pulse(2, 0);
    chk(q, 12'hF0C);
  endtask : run_source_choice
  task automatic run_open_pair;
    d.pos_open = 1;
    d.neg_open = 1;
    pulse(2, 0);
    chk(q, 12'hF0C);
  endtask : run_open_pair
  task automatic run_restart;
    nrst = 0;
    @(negedge mclk);
    chk(q, 12'h0F3);
    chk(12'(nq), 12'h002);
    d.pos_open = 0;
    d.neg_open = 0;
    nrst = 1;
    pulse(1, 0);
    chk(q, 12'hF0C);
    chk(12'(nq), 12'h003);
  endtask : run_restart
  initial begin
    run_reset_entry();
    run_ttl_division();
    run_source_choice();
    run_open_pair();
    run_restart();
    complete_run();
  end
endmodule : dscd_divider_bench
